// File: common/adv_regs_pkg.sv
package adv_regs_pkg;

	// -----------------------------------------------------------------
	// management frame fields
	// -----------------------------------------------------------------
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [3:0] HDR_LAST = 4'hB;
	localparam logic [3:0] DATA_LAST = 4'hF;
	localparam logic [3:0] TA_FIRST = 4'h0;

	// -----------------------------------------------------------------
	// register map
	// -----------------------------------------------------------------
	localparam logic [4:0] ADDR_ID_LOW = 5'h03;
	localparam logic [4:0] ADDR_ADV = 5'h04;
	localparam logic [15:0] ADV_NOMINAL = 16'h01E1;
	localparam logic [15:0] ADV_WR_MASK = 16'hBDE0;
	localparam int ADV_NP = 15;
	localparam int ADV_RSV = 14;
	localparam int ADV_RF = 13;
	localparam int ADV_ENP = 12;
	localparam int ADV_APAUSE = 11;
	localparam int ADV_PAUSE = 10;
	localparam int ADV_T4 = 9;
	localparam int ADV_SPD_HI = 8;
	localparam int ADV_SPD_LO = 5;
	localparam int ADV_SEL_HI = 4;
	localparam logic [4:0] SEL_ETHERNET = 5'h01;
	localparam logic [3:0] SPEED_NOMINAL = 4'hF;

	// -----------------------------------------------------------------
	// types
	// -----------------------------------------------------------------
	typedef enum logic [2:0] {MDIO_IDLE, MDIO_START, MDIO_HDR, MDIO_TA, MDIO_DATA} mdio_fsm_t;
	typedef enum logic {NP_BASE, NP_EXCHANGE} np_phase_t;

	typedef struct packed {
		logic page_done;
		logic partner_np;
		logic local_more;
	} np_in_t;

	typedef struct packed {
		mdio_fsm_t fsm;
		logic [3:0] cnt;
		logic [11:0] hdr;
		logic [15:0] sh;
		logic rd;
		logic sel;
		logic mdc_prev;
		logic mdio_out;
		logic mdio_oe_n;
		logic np;
		logic rf;
		logic enp;
		logic apause;
		logic pause;
		logic [3:0] speed;
		logic loaded;
		np_phase_t np_phase;
	} state_t;

	localparam state_t STATE_RESET = '{
		fsm: MDIO_IDLE, cnt: 4'h0, hdr: 12'h000, sh: 16'h0000, rd: 1'b0,
		sel: 1'b0, mdc_prev: 1'b0, mdio_out: 1'b0, mdio_oe_n: 1'b1,
		np: 1'b0, rf: 1'b0, enp: 1'b0, apause: 1'b0, pause: 1'b0,
		speed: SPEED_NOMINAL, loaded: 1'b0, np_phase: NP_BASE};

endpackage

// File: logic/autoneg_advertise_regs.sv
// Behaviour
// [RL1] identifier bits 9:4 hold a read-only model number; writes ignored
// [RL2] identifier bits 3:0 hold a read-only revision number; writes ignored
// [RL3] identifier bits 15:10 hold six read-only upper vendor identifier bits
// [RL4] advertisement register decoded at address 0x04, nominal reset 0x01E1
// [RL5] advertisement reset value follows sampled configuration pins
// [RL6] writable next page bit 15, reset zero, enables next page exchange
// [RL7] next page exchange ends only when both ends send next page zero
// [RL8] writable remote fault bit 13, reset zero, sent to link partner
// [RL9] writable extended next page bit 12, reset zero
// [RL10] bits 11:5 form the seven-bit technology ability field
// [RL11] writable asymmetric pause bit 11, reset zero
// [RL12] writable symmetric pause bit 10, reset zero
// [RL13] four-pair 100 Mbit bit is read-only and reads zero
// [RL14] writable 100 Mbit full duplex bit, nominal reset one
// [RL15] writable 100 Mbit half duplex bit, nominal reset one
// [RL16] writable 10 Mbit full duplex bit, nominal reset one
// [RL17] writable 10 Mbit half duplex bit 5, nominal reset one
// [RL18] the four speed bits load their defaults from configuration pins
// [RL19] selector bits 4:0 always read one, the Ethernet selector
// [RL20] bits 9..6 are four-pair 100, 100 full, 100 half, 10 full
// [RL21] reserved bit 14 reads zero and ignores writes
`timescale 1ns/1ns
module autoneg_advertise_regs
	import adv_regs_pkg::*;
#(
	// arbitrary identification values
	parameter logic [5:0] OUI_UPPER = 6'h2A,
	parameter logic [5:0] PART_MODEL = 6'h15,
	parameter logic [3:0] SILICON_REV = 4'h7
)
(
	input wire logic I_CLK,
	input wire logic I_NRST,
	input wire logic I_MDC,
	input wire logic I_MDIO,
	output logic O_MDIO,
	output logic O_MDIO_OE_N,
	input wire logic [4:0] I_PHY_ADDR,
	input wire logic [3:0] I_CFG_SPEED,
	input wire np_in_t I_NP,
	output logic [15:0] O_ADV_WORD,
	output logic O_NP_ACTIVE
);

	// -----------------------------------------------------------------
	// reset release
	// -----------------------------------------------------------------
	logic rst_meta_reg;
	logic rst_n_reg;

	always_ff @(posedge I_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	// -----------------------------------------------------------------
	// register contents
	// -----------------------------------------------------------------
	state_t st_reg;
	state_t st_next;
	logic mdc_rise;
	logic bit_in;
	logic [11:0] hdr_full;
	logic [15:0] wr_word;
	logic wr_commit;
	logic [15:0] id_word;

	function automatic logic [15:0] adv_value(input state_t s);
		logic [15:0] v;
		v = 16'h0000;
		v[ADV_NP] = s.np;
		// [RL21] reserved reads zero
		v[ADV_RSV] = 1'b0;
		v[ADV_RF] = s.rf;
		v[ADV_ENP] = s.enp;
		v[ADV_APAUSE] = s.apause;
		v[ADV_PAUSE] = s.pause;
		// [RL13] four-pair reads zero
		v[ADV_T4] = 1'b0;
		v[ADV_SPD_HI:ADV_SPD_LO] = s.speed;
		// [RL19] fixed Ethernet selector
		v[ADV_SEL_HI:0] = SEL_ETHERNET;
		return v;
	endfunction

	// [RL1] fixed identifier
	// [RL2] and [RL3] fields
	assign id_word = {OUI_UPPER, PART_MODEL, SILICON_REV};

	assign mdc_rise = I_MDC & ~st_reg.mdc_prev;
	assign bit_in = I_MDIO;
	assign hdr_full = {st_reg.hdr[10:0], bit_in};
	assign wr_word = {st_reg.sh[14:0], bit_in};
	assign wr_commit = mdc_rise && st_reg.fsm == MDIO_DATA && !st_reg.rd
		&& st_reg.sel && st_reg.cnt == DATA_LAST && st_reg.hdr[4:0] == ADDR_ADV;

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb
	begin
		st_next = st_reg;
		st_next.mdc_prev = I_MDC;
		// [RL5] strap load
		// [RL18] after release
		if (!st_reg.loaded)
		begin
			st_next.loaded = 1'b1;
			st_next.speed = I_CFG_SPEED;
		end
		if (mdc_rise)
		begin
			case (st_reg.fsm)
				MDIO_IDLE:
				begin
					if (!bit_in)
					begin
						st_next.fsm = MDIO_START;
					end
				end
				MDIO_START:
				begin
					st_next.fsm = bit_in ? MDIO_HDR : MDIO_IDLE;
					st_next.cnt = 4'h0;
				end
				MDIO_HDR:
				begin
					st_next.hdr = hdr_full;
					st_next.cnt = st_reg.cnt + 4'h1;
					if (st_reg.cnt == HDR_LAST)
					begin
						st_next.fsm = MDIO_TA;
						st_next.cnt = TA_FIRST;
						st_next.rd = hdr_full[11:10] == OP_READ;
						st_next.sel = hdr_full[9:5] == I_PHY_ADDR
							&& (hdr_full[11:10] == OP_READ
							|| hdr_full[11:10] == OP_WRITE);
						// [RL4] address decode
						if (hdr_full[4:0] == ADDR_ADV)
						begin
							st_next.sh = adv_value(st_reg);
						end
						else if (hdr_full[4:0] == ADDR_ID_LOW)
						begin
							st_next.sh = id_word;
						end
						else
						begin
							st_next.sh = 16'h0000;
						end
					end
				end
				MDIO_TA:
				begin
					st_next.cnt = st_reg.cnt + 4'h1;
					if (st_reg.rd && st_reg.sel)
					begin
						st_next.mdio_oe_n = 1'b0;
						st_next.mdio_out = 1'b0;
					end
					if (st_reg.cnt != TA_FIRST)
					begin
						st_next.fsm = MDIO_DATA;
						st_next.cnt = 4'h0;
						if (st_reg.rd)
						begin
							st_next.mdio_out = st_reg.sh[15];
							st_next.sh = {st_reg.sh[14:0], 1'b0};
						end
					end
				end
				MDIO_DATA:
				begin
					st_next.cnt = st_reg.cnt + 4'h1;
					if (st_reg.rd)
					begin
						st_next.mdio_out = st_reg.sh[15];
						st_next.sh = {st_reg.sh[14:0], 1'b0};
					end
					else
					begin
						st_next.sh = wr_word;
					end
					if (st_reg.cnt == DATA_LAST)
					begin
						st_next.fsm = MDIO_IDLE;
						st_next.mdio_oe_n = 1'b1;
						st_next.mdio_out = 1'b0;
					end
				end
				default:
				begin
					st_next.fsm = MDIO_IDLE;
				end
			endcase
		end
		// [RL6] writable bits
		// [RL8] [RL9] [RL11] [RL12] fields
		if (wr_commit)
		begin
			st_next.np = wr_word[ADV_NP];
			st_next.rf = wr_word[ADV_RF];
			st_next.enp = wr_word[ADV_ENP];
			st_next.apause = wr_word[ADV_APAUSE];
			st_next.pause = wr_word[ADV_PAUSE];
			// [RL14] [RL15] [RL16] [RL17] speed bits
			st_next.speed = wr_word[ADV_SPD_HI:ADV_SPD_LO];
		end
		// [RL6] enter next pages
		// [RL7] leave when both zero
		if (I_NP.page_done)
		begin
			if (st_reg.np_phase == NP_BASE)
			begin
				if (st_reg.np || I_NP.partner_np)
				begin
					st_next.np_phase = NP_EXCHANGE;
				end
			end
			else if (!I_NP.local_more && !I_NP.partner_np)
			begin
				st_next.np_phase = NP_BASE;
			end
		end
	end

	always_ff @(posedge I_CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			st_reg <= STATE_RESET;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// -----------------------------------------------------------------
	// outputs
	// -----------------------------------------------------------------
	assign O_MDIO = st_reg.mdio_out;
	assign O_MDIO_OE_N = st_reg.mdio_oe_n;
	// [RL10] technology field
	// [RL20] bit order
	assign O_ADV_WORD = adv_value(st_reg);
	assign O_NP_ACTIVE = st_reg.np_phase == NP_EXCHANGE;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!rst_n_reg);

	sequence seq_wr_commit;
		wr_commit;
	endsequence

	sequence seq_np_final_page;
		O_NP_ACTIVE && I_NP.page_done && !I_NP.partner_np && !I_NP.local_more;
	endsequence

	sequence seq_read_ta;
		mdc_rise && st_reg.fsm == MDIO_TA && st_reg.rd && st_reg.sel
			&& st_reg.cnt != TA_FIRST;
	endsequence

	AST_SELECTOR_ONE: assert property (O_ADV_WORD[ADV_SEL_HI:0] == SEL_ETHERNET) // [RL19]
		else $error("selector field not one");
	AST_RESERVED_ZERO: assert property (!O_ADV_WORD[ADV_RSV]) // [RL21]
		else $error("reserved bit 14 set");
	AST_T4_ZERO: assert property (!O_ADV_WORD[ADV_T4]) // [RL13]
		else $error("four-pair bit set");
	AST_STRAP_LOAD: assert property ($rose(st_reg.loaded) |-> // [RL18]
		O_ADV_WORD[ADV_SPD_HI:ADV_SPD_LO] == $past(I_CFG_SPEED))
		else $error("speed defaults not taken from pins");
	AST_WRITE_TAKES: assert property (seq_wr_commit |=> // [RL6]
		(O_ADV_WORD & ADV_WR_MASK) == ($past(wr_word) & ADV_WR_MASK))
		else $error("advertisement write not applied");
	AST_NP_ENTER: assert property (!O_NP_ACTIVE && I_NP.page_done // [RL6]
		&& O_ADV_WORD[ADV_NP] |=> O_NP_ACTIVE)
		else $error("next page exchange not entered");
	AST_NP_END: assert property (seq_np_final_page |=> !O_NP_ACTIVE) // [RL7]
		else $error("next page exchange did not end");
	AST_NP_HOLD: assert property (O_NP_ACTIVE && !(I_NP.page_done // [RL7]
		&& !I_NP.partner_np && !I_NP.local_more) |=> O_NP_ACTIVE)
		else $error("next page exchange ended early");
	AST_READ_DRIVE: assert property (seq_read_ta |=> // [RL4]
		!O_MDIO_OE_N && O_MDIO == $past(st_reg.sh[15]))
		else $error("read data not driven after turnaround");

endmodule

// File: tb/mdio_host.sv
`timescale 1ns/1ns
module mdio_host
	import adv_regs_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_mdio,
	output logic o_mdc,
	output logic o_mdio,
	output logic o_drive
);
	// ----------------------------------------
	// management frame master
	// ----------------------------------------
	initial
	begin
		o_mdc = 1'b0;
		o_mdio = 1'b1;
		o_drive = 1'b0;
	end

	// reads let go of the line from turnaround on; bits are sampled just before each rise
	task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [31:0] f;
		f = {2'h1, op, pa, ra, 2'h2, wd};
		rd = 16'h0000;
		for (int i = 31; i >= 0; i--)
		begin
			@(posedge i_clk);
			o_mdc <= 1'b0;
			o_mdio <= f[i];
			o_drive <= (op != OP_READ) || (i > 17);
			repeat (2) @(posedge i_clk);
			if (i < 16)
				rd[i] = i_mdio;
			o_mdc <= 1'b1;
			@(posedge i_clk);
		end
		@(posedge i_clk);
		o_mdc <= 1'b0;
		o_drive <= 1'b0;
	endtask
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ns
module tb_top
	import adv_regs_pkg::*;
;
	// arbitrary identification values
	localparam logic [5:0] OUI = 6'h2A;
	localparam logic [5:0] MODEL = 6'h15;
	localparam logic [3:0] REV = 4'h7;
	localparam logic [4:0] PHY = 5'h09;
	logic clk, nrst, mdc, mdio_wire, dut_mdio, dut_oe_n, np_active, host_mdio, host_drive;
	logic [3:0] cfg;
	logic [15:0] adv, rd, w;
	np_in_t np;
	int num_errors, checks, seed, adv_m, np_m;

	// pull-up holds the line high when nobody drives it
	assign mdio_wire = !dut_oe_n ? dut_mdio : (host_drive ? host_mdio : 1'b1);

	autoneg_advertise_regs #(.OUI_UPPER(OUI), .PART_MODEL(MODEL), .SILICON_REV(REV)) u_dut (
		.I_CLK(clk), .I_NRST(nrst), .I_MDC(mdc), .I_MDIO(mdio_wire), .O_MDIO(dut_mdio),
		.O_MDIO_OE_N(dut_oe_n), .I_PHY_ADDR(PHY), .I_CFG_SPEED(cfg), .I_NP(np),
		.O_ADV_WORD(adv), .O_NP_ACTIVE(np_active));
	mdio_host u_host (.i_clk(clk), .i_mdio(mdio_wire), .o_mdc(mdc), .o_mdio(host_mdio),
		.o_drive(host_drive));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ----------------------------------------
	// checking and bus tasks
	// ----------------------------------------
	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch %0s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	function automatic int keep(int v);
		return (v & 16'hBDE0) | 1;
	endfunction
	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		u_host.xfer(OP_WRITE, PHY, ra, d, rd);
		repeat (2) @(posedge clk);
	endtask
	task automatic rdreg(input logic [4:0] ra);
		u_host.xfer(OP_READ, PHY, ra, 16'h0000, rd);
	endtask
	task automatic do_reset(input logic [3:0] c);
		@(posedge clk);
		nrst <= 1'b0;
		cfg <= c;
		repeat (2) @(posedge clk);
		cmp("adv in reset", 16'h01E1, adv);
		nrst <= 1'b1;
		repeat (5) @(posedge clk);
		adv_m = {7'h00, c, 5'h01};
		np_m = 0;
		cmp("adv after reset", adv_m[15:0], adv);
		cmp("np after reset", 16'h0000, {15'h0000, np_active});
	endtask
	task automatic page(input logic pnp, input logic lm);
		@(posedge clk);
		np <= '{page_done: 1'b1, partner_np: pnp, local_more: lm};
		@(posedge clk);
		np <= '{default: 1'b0};
		@(negedge clk);
		np_m = (np_m == 0) ? (adv_m[15] | pnp) : (pnp | lm);
		cmp("np active", np_m[15:0], {15'h0000, np_active});
	endtask

	initial
	begin
		repeat (100000) @(posedge clk);
		num_errors++;
		stop_test();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		seed = 57;
		nrst = 1'b0;
		cfg = 4'h0;
		np = '{default: 1'b0};
		num_errors = 0;
		checks = 0;
		do_reset(4'hF);
		rdreg(ADDR_ADV);
		cmp("read adv", adv_m[15:0], rd);
		wr(ADDR_ID_LOW, 16'h0000);
		rdreg(ADDR_ID_LOW);
		cmp("read id", {OUI, MODEL, REV}, rd);
		rdreg(5'h07);
		cmp("read unmapped", 16'h0000, rd);
		$display("test identity done");
		for (int i = 0; i < 10; i++)
		begin
			w = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($random(seed));
			wr(ADDR_ADV, w);
			adv_m = keep(w);
			cmp("adv word", adv_m[15:0], adv);
			rdreg(ADDR_ADV);
			cmp("read adv", adv_m[15:0], rd);
		end
		$display("test write done");
		for (int k = 0; k < 3; k++)
		begin
			u_host.xfer(k == 2 ? OP_WRITE : 2'(k * 3), k == 2 ? PHY ^ 5'h01 : PHY, ADDR_ADV,
				~adv_m[15:0], rd);
			repeat (2) @(posedge clk);
			cmp("adv refused", adv_m[15:0], adv);
		end
		$display("test refused done");
		wr(ADDR_ADV, 16'h0000);
		adv_m = keep(0);
		page(1'b0, 1'b0);
		page(1'b1, 1'b0);
		page(1'b0, 1'b1);
		page(1'b1, 1'b0);
		page(1'b0, 1'b0);
		wr(ADDR_ADV, 16'h8000);
		adv_m = keep(16'h8000);
		page(1'b0, 1'b0);
		page(1'b0, 1'b0);
		$display("test next page done");
		do_reset(4'($random(seed)));
		rdreg(ADDR_ADV);
		cmp("read adv", adv_m[15:0], rd);
		$display("test second reset done");
		stop_test();
	end
endmodule
